/* File: cwh_regs.svh */
// constants for the codeword handshake link and its two ends
`ifndef CWH_REGS_SVH
`define CWH_REGS_SVH

`define CWH_CLK_MHZ        200
`define CWH_CONFIRM_MS     2000
`define CWH_LAMP_MS        20000
`define CWH_STRIKE_MS      5000
`define CWH_MAX_TRIES      3'h4
`define CWH_CW_W           8
`define CWH_HALF_W         4
`define CWH_LFSR_SEED      16'hACE1
`define CWH_ERR_HANDSHAKE  8'h01
`define CWH_FLASH_BIT      26

`endif

/* File: cwh_pkg.sv */
// shared types of the codeword handshake link
package cwh_pkg;

   typedef enum logic [2:0] {
      CWH_MSG_ARM_REQ = 3'h0,
      CWH_MSG_DATA1   = 3'h1,
      CWH_MSG_CONF1   = 3'h2,
      CWH_MSG_DATA2   = 3'h3,
      CWH_MSG_CONF2   = 3'h4,
      CWH_MSG_OK      = 3'h5,
      CWH_MSG_DIGIT   = 3'h6,
      CWH_MSG_STRIKE  = 3'h7
   } cwh_msg_e;

   typedef enum logic [2:0] {
      CWH_C_POWERUP = 3'h0,
      CWH_C_IDLE    = 3'h1,
      CWH_C_START   = 3'h2,
      CWH_C_SEND    = 3'h3,
      CWH_C_WAIT    = 3'h4,
      CWH_C_NEXT    = 3'h5
   } cwh_cstate_e;

endpackage : cwh_pkg

/* File: cwh_link_if.sv */
// message link between the central processor and the keypad units
interface cwh_link_if #(
   parameter int UNIT_W = 1
);
   logic                  c2k_valid;
   cwh_pkg::cwh_msg_e     c2k_type;
   logic [UNIT_W-1:0]     c2k_unit;
   logic [7:0]            c2k_data;
   logic                  k2c_valid;
   cwh_pkg::cwh_msg_e     k2c_type;
   logic [UNIT_W-1:0]     k2c_unit;
   logic [7:0]            k2c_data;

   modport central (
      output c2k_valid, c2k_type, c2k_unit, c2k_data,
      input  k2c_valid, k2c_type, k2c_unit, k2c_data
   );

   modport keypad (
      input  c2k_valid, c2k_type, c2k_unit, c2k_data,
      output k2c_valid, k2c_type, k2c_unit, k2c_data
   );
endinterface : cwh_link_if

/* File: cwh_keypad.sv */
// keypad unit end: codeword store, digit encoding, lamp and strike timing
`include "cwh_regs.svh"
module cwh_keypad #(
   parameter int          UNIT_W     = 1,
   parameter int          UNIT_ID    = 0,
   parameter logic [31:0] LAMP_CYC   = 32'(64'(`CWH_LAMP_MS) * 64'(`CWH_CLK_MHZ) * 64'd1000),
   parameter logic [31:0] STRIKE_CYC = 32'(64'(`CWH_STRIKE_MS) * 64'(`CWH_CLK_MHZ) * 64'd1000),
   parameter int          FLASH_BIT  = `CWH_FLASH_BIT
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   cwh_link_if.keypad       lk,
   input  wire logic        arm_button,
   input  wire logic        door_closed,
   input  wire logic        digit_valid,
   input  wire logic [3:0]  digit,
   output logic             digit_ready,
   output logic             trouble_lamp,
   output logic             strike,
   output logic [7:0]       codeword
);
   typedef struct packed {
      logic [1:0]         s1;
      logic [1:0]         s2;
      logic               armc;
      logic               pend_arm;
      logic               pend_dig;
      logic [3:0]         dig_enc;
      logic [1:0]         dcnt;
      logic [3:0]         held;
      logic [7:0]         cw;
      logic [31:0]        lamp_t;
      logic               flash;
      logic [31:0]        strike_t;
      logic               lamp;
      logic               strk;
      logic               tx_v;
      cwh_pkg::cwh_msg_e  tx_t;
      logic [7:0]         tx_d;
   } cwh_keypad_s;

   cwh_keypad_s q;
   cwh_keypad_s d;
   logic        mine;
   logic        arm_now;

   always_comb begin
      d         = q;
      d.tx_v    = 1'b0;
      d.s1      = {arm_button, door_closed};
      d.s2      = q.s1;
      arm_now   = q.s2[1] & q.s2[0];
      d.armc    = arm_now;
      mine      = lk.c2k_valid && (lk.c2k_unit == UNIT_W'(UNIT_ID));
      if (q.lamp_t != 32'h0) d.lamp_t = q.lamp_t - 32'h1;
      if (q.strike_t != 32'h0) d.strike_t = q.strike_t - 32'h1;
      // echoes take the link first; digits and arm requests wait one cycle
      if (mine && lk.c2k_type == cwh_pkg::CWH_MSG_DATA1) begin
         d.held = lk.c2k_data[3:0];
         d.tx_v = 1'b1;
         d.tx_t = cwh_pkg::CWH_MSG_CONF1;
         d.tx_d = {4'h0, lk.c2k_data[3:0]};
      end else if (mine && lk.c2k_type == cwh_pkg::CWH_MSG_DATA2) begin
         d.cw   = {q.held, lk.c2k_data[3:0]};
         d.dcnt = 2'h0;
         d.tx_v = 1'b1;
         d.tx_t = cwh_pkg::CWH_MSG_CONF2;
         d.tx_d = {4'h0, lk.c2k_data[3:0]};
      end else if (q.pend_dig) begin
         d.pend_dig = 1'b0;
         d.tx_v     = 1'b1;
         d.tx_t     = cwh_pkg::CWH_MSG_DIGIT;
         d.tx_d     = {4'h0, q.dig_enc};
      end else if (q.pend_arm) begin
         d.pend_arm = 1'b0;
         d.tx_v     = 1'b1;
         d.tx_t     = cwh_pkg::CWH_MSG_ARM_REQ;
         d.tx_d     = 8'h00;
      end
      if (mine && (lk.c2k_type == cwh_pkg::CWH_MSG_OK || lk.c2k_type == cwh_pkg::CWH_MSG_STRIKE)) begin
         d.lamp_t = LAMP_CYC;
         d.flash  = lk.c2k_data[0];
      end
      if (mine && lk.c2k_type == cwh_pkg::CWH_MSG_STRIKE) d.strike_t = STRIKE_CYC;
      if (digit_valid && !q.pend_dig) begin
         d.pend_dig = 1'b1;
         // first and third digits use the upper half
         d.dig_enc  = digit ^ (q.dcnt[0] ? q.cw[3:0] : q.cw[7:4]);
         d.dcnt     = q.dcnt + 2'h1;
      end
      if (arm_now && !q.armc) d.pend_arm = 1'b1;
      d.lamp = (d.lamp_t != 32'h0) && (!d.flash || d.lamp_t[FLASH_BIT]);
      d.strk = d.strike_t != 32'h0;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) q <= '0;
      else q <= d;
   end

   assign digit_ready  = !q.pend_dig;
   assign trouble_lamp = q.lamp;
   assign strike       = q.strk;
   assign codeword     = q.cw;
   assign lk.k2c_valid = q.tx_v;
   assign lk.k2c_type  = q.tx_t;
   assign lk.k2c_unit  = UNIT_W'(UNIT_ID);
   assign lk.k2c_data  = q.tx_d;
endmodule : cwh_keypad

/* File: cwh_central.sv */
// central processor end: codeword handshake with every keypad unit, digit decoding
// Functional notes
// - both ends share one eight-bit codeword
// - keypad xors digits with alternating codeword halves
// - central decodes digits with matching half
// - new random codeword on arming and power-up
// - handshake data rides in data field
// - keypad sends arm request on button, door closed
// - handshake each keypad unit in turn
// - begin with upper half in first data
// - keypad holds first half, echoes it
// - resend on timeout or bad echo, four tries
// - fourth failure: abandon, push error, keep codeword
// - then send lower half, same retry scheme
// - keypad adopts both halves, echoes second
// - abort after four failed second-half tries
// - adopt codeword, send acknowledge, next unit
// - acknowledge carries system trouble bit
// - keypad lamp twenty seconds, flashing on trouble
// - keypad sends each encoded digit separately
// - fourth matching digit disarms, sends release
// - keypad strike five seconds plus lamp
`include "cwh_regs.svh"
module cwh_central #(
   parameter int          NUM_UNITS   = 2,
   parameter int          UNIT_W      = 1,
   parameter logic [31:0] CONFIRM_CYC = 32'(64'(`CWH_CONFIRM_MS) * 64'(`CWH_CLK_MHZ) * 64'd1000)
) (
   input  wire logic                            mclk,
   input  wire logic                            rst_b,
   cwh_link_if.central                          lk,
   input  wire logic                            arm_cmd,
   input  wire logic                            trouble,
   input  wire logic [15:0]                     combination,
   output logic                                 armed,
   output logic                                 busy,
   output logic                                 disarm_pulse,
   output logic                                 err_push,
   output logic [7:0]                           err_code,
   output logic [UNIT_W-1:0]                    err_unit,
   output logic [NUM_UNITS-1:0][7:0]            codewords
);
   localparam logic [UNIT_W-1:0] LAST_UNIT = UNIT_W'(NUM_UNITS - 1);

   typedef struct packed {
      cwh_pkg::cwh_cstate_e        st;
      logic                        half;
      logic [2:0]                  tries;
      logic [31:0]                 timer;
      logic [UNIT_W-1:0]           unit;
      logic [7:0]                  new_cw;
      logic [NUM_UNITS-1:0][7:0]   cw;
      logic                        armed;
      logic                        arm_after;
      logic                        pend_arm;
      logic [1:0]                  dcnt;
      logic                        dmatch;
      logic [15:0]                 lfsr;
      logic                        tx_v;
      cwh_pkg::cwh_msg_e           tx_t;
      logic [UNIT_W-1:0]           tx_u;
      logic [7:0]                  tx_d;
      logic                        err;
      logic [UNIT_W-1:0]           err_u;
      logic                        disarm;
   } cwh_central_s;

   cwh_central_s q;
   cwh_central_s d;
   logic         rx;
   logic         from_unit;
   logic         conf_type;
   logic [3:0]   sent_half;
   logic [7:0]   ucw;
   logic [3:0]   dec;
   logic [3:0]   want;
   logic         hit;

   always_comb begin
      d         = q;
      d.tx_v    = 1'b0;
      d.err     = 1'b0;
      d.disarm  = 1'b0;
      // free-running lfsr, sampled once per unit as the fresh codeword
      d.lfsr    = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
      rx        = lk.k2c_valid;
      from_unit = rx && (lk.k2c_unit == q.unit);
      conf_type = lk.k2c_type == (q.half ? cwh_pkg::CWH_MSG_CONF2 : cwh_pkg::CWH_MSG_CONF1);
      sent_half = q.half ? q.new_cw[3:0] : q.new_cw[7:4];
      ucw       = q.cw[lk.k2c_unit];
      dec       = lk.k2c_data[3:0] ^ (q.dcnt[0] ? ucw[3:0] : ucw[7:4]);
      want      = combination[4'(15 - 4 * int'(q.dcnt)) -: 4];
      hit       = (q.dcnt == 2'h0 || q.dmatch) && (dec == want);
      unique case (q.st)
         cwh_pkg::CWH_C_POWERUP: begin
            d.unit      = '0;
            d.arm_after = 1'b0;
            d.st        = cwh_pkg::CWH_C_START;
         end
         cwh_pkg::CWH_C_IDLE: begin
            if (q.pend_arm) begin
               d.pend_arm  = 1'b0;
               d.arm_after = 1'b1;
               d.unit      = '0;
               d.st        = cwh_pkg::CWH_C_START;
            end else if (rx && lk.k2c_type == cwh_pkg::CWH_MSG_DIGIT) begin
               d.dmatch = hit;
               d.dcnt   = q.dcnt + 2'h1;
               if (q.dcnt == 2'h3 && hit && q.armed) begin
                  d.armed  = 1'b0;
                  d.disarm = 1'b1;
                  d.tx_v   = 1'b1;
                  d.tx_t   = cwh_pkg::CWH_MSG_STRIKE;
                  d.tx_u   = lk.k2c_unit;
                  d.tx_d   = {7'h00, trouble};
               end
            end
         end
         cwh_pkg::CWH_C_START: begin
            d.new_cw = q.lfsr[7:0];
            d.half   = 1'b0;
            d.tries  = 3'h0;
            d.st     = cwh_pkg::CWH_C_SEND;
         end
         cwh_pkg::CWH_C_SEND: begin
            d.tx_v  = 1'b1;
            d.tx_t  = q.half ? cwh_pkg::CWH_MSG_DATA2 : cwh_pkg::CWH_MSG_DATA1;
            d.tx_u  = q.unit;
            d.tx_d  = {4'h0, sent_half};
            d.tries = q.tries + 3'h1;
            d.timer = CONFIRM_CYC;
            d.st    = cwh_pkg::CWH_C_WAIT;
         end
         cwh_pkg::CWH_C_WAIT: begin
            d.timer = q.timer - 32'h1;
            if (from_unit && conf_type && lk.k2c_data[3:0] == sent_half) begin
               if (!q.half) begin
                  d.half  = 1'b1;
                  d.tries = 3'h0;
                  d.st    = cwh_pkg::CWH_C_SEND;
               end else begin
                  d.cw[q.unit] = q.new_cw;
                  d.tx_v       = 1'b1;
                  d.tx_t       = cwh_pkg::CWH_MSG_OK;
                  d.tx_u       = q.unit;
                  d.tx_d       = {7'h00, trouble};
                  d.st         = cwh_pkg::CWH_C_NEXT;
               end
            end else if ((from_unit && conf_type) || q.timer == 32'h1) begin
               // bad echo resends at once rather than waiting out the timer
               if (q.tries == `CWH_MAX_TRIES) begin
                  d.err   = 1'b1;
                  d.err_u = q.unit;
                  d.st    = cwh_pkg::CWH_C_NEXT;
               end else begin
                  d.st = cwh_pkg::CWH_C_SEND;
               end
            end
         end
         cwh_pkg::CWH_C_NEXT: begin
            if (q.unit == LAST_UNIT) begin
               d.armed = q.armed | q.arm_after;
               d.st    = cwh_pkg::CWH_C_IDLE;
            end else begin
               d.unit = q.unit + UNIT_W'(1);
               d.st   = cwh_pkg::CWH_C_START;
            end
         end
         default: d.st = cwh_pkg::CWH_C_IDLE;
      endcase
      // a request arriving during a handshake is held, set wins over the clear
      if (arm_cmd || (rx && lk.k2c_type == cwh_pkg::CWH_MSG_ARM_REQ)) d.pend_arm = 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         q      <= '0;
         q.lfsr <= `CWH_LFSR_SEED;
      end else begin
         q <= d;
      end
   end

   assign armed        = q.armed;
   assign busy         = q.st != cwh_pkg::CWH_C_IDLE;
   assign disarm_pulse = q.disarm;
   assign err_push     = q.err;
   assign err_code     = `CWH_ERR_HANDSHAKE;
   assign err_unit     = q.err_u;
   assign codewords    = q.cw;
   assign lk.c2k_valid = q.tx_v;
   assign lk.c2k_type  = q.tx_t;
   assign lk.c2k_unit  = q.tx_u;
   assign lk.c2k_data  = q.tx_d;
endmodule : cwh_central

/* File: cwh_link_checker.sv */
// concurrent checks on the central to keypad message link
module cwh_link_checker #(
   parameter int          UNIT_W      = 1,
   parameter logic [31:0] CONFIRM_CYC = 32'h14
) (
   input wire logic              mclk,
   input wire logic              rst_b,
   input wire logic              c2k_valid,
   input wire cwh_pkg::cwh_msg_e c2k_type,
   input wire logic [UNIT_W-1:0] c2k_unit,
   input wire logic [7:0]        c2k_data,
   input wire logic              k2c_valid,
   input wire cwh_pkg::cwh_msg_e k2c_type,
   input wire logic [UNIT_W-1:0] k2c_unit,
   input wire logic [7:0]        k2c_data
);
   typedef struct packed {
      logic [31:0] gap;
      logic [2:0]  tries;
   } cwh_chk_s;
   cwh_chk_s st_q;
   cwh_chk_s st_d;
   // tries counts back-to-back first-half sends to the silent unit 1
   always_comb begin
      st_d = st_q;
      st_d.gap = st_q.gap + 32'h1;
      if (c2k_valid) begin
         st_d.gap = 32'h0;
         st_d.tries = (c2k_unit != '0 && c2k_type == cwh_pkg::CWH_MSG_DATA1) ? st_q.tries + 3'h1 : 3'h0;
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) st_q <= '0;
      else st_q <= st_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   AST_ECHO1: assert property (c2k_valid && c2k_type == cwh_pkg::CWH_MSG_DATA1 && c2k_unit == '0
      |=> k2c_valid && k2c_type == cwh_pkg::CWH_MSG_CONF1 && k2c_data == $past(c2k_data)) else $error("bad first echo");
   AST_ECHO2: assert property (c2k_valid && c2k_type == cwh_pkg::CWH_MSG_DATA2 && c2k_unit == '0
      |=> k2c_valid && k2c_type == cwh_pkg::CWH_MSG_CONF2 && k2c_data == $past(c2k_data)) else $error("bad second echo");
   AST_HALF_FIELD: assert property (c2k_valid && c2k_type inside {cwh_pkg::CWH_MSG_DATA1, cwh_pkg::CWH_MSG_DATA2}
      |-> c2k_data[7:4] == 4'h0) else $error("half message upper bits set");
   AST_FLAG_FIELD: assert property (c2k_valid && c2k_type inside {cwh_pkg::CWH_MSG_OK, cwh_pkg::CWH_MSG_STRIKE}
      |-> c2k_data[7:1] == 7'h00) else $error("flag message extra bits set");
   AST_SPACING: assert property (c2k_valid |=> !c2k_valid) else $error("messages too close");
   AST_SECOND_HALF: assert property (k2c_valid && k2c_type == cwh_pkg::CWH_MSG_CONF1
      |-> ##[1:3] c2k_valid && c2k_type == cwh_pkg::CWH_MSG_DATA2) else $error("no second half");
   AST_ACK: assert property (k2c_valid && k2c_type == cwh_pkg::CWH_MSG_CONF2
      |-> ##[1:3] c2k_valid && c2k_type == cwh_pkg::CWH_MSG_OK && c2k_unit == '0) else $error("no acknowledge");
   AST_TRIES: assert property (c2k_valid && c2k_unit != '0 |-> st_q.tries < 3'h4) else $error("over four sends");
   AST_RETRY_GAP: assert property (c2k_valid && c2k_unit != '0 && st_q.tries != 3'h0
      |-> st_q.gap >= CONFIRM_CYC - 32'h1 && st_q.gap <= CONFIRM_CYC + 32'h4) else $error("resend timing off");
   COV_FOURTH: cover property (c2k_valid && st_q.tries == 3'h3);
endmodule : cwh_link_checker

/* File: codeword_handshake_unlock_test.sv */
// bench: central and one keypad on the link, unit 1 left silent
module codeword_handshake_unlock_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic            mclk, rst_b, arm_cmd, trouble, armed, busy, disarm_pulse, err_push;
   logic            arm_button, door_closed, digit_valid, digit_ready, trouble_lamp, strike, tr;
   logic [15:0]     combination, comb;
   logic [7:0]      err_code, codeword, cw_exp, obs;
   logic [0:0]      err_unit;
   logic [1:0][7:0] codewords;
   logic [3:0]      digit, hi;
   logic [31:0]     rnd;
   logic [7:0]      exp_q[$];
   int              err_count = 0;
   int              checks = 0;
   int              cyc = 0;
   int              n_hi;
   cwh_link_if lk ();
   cwh_central #(.CONFIRM_CYC(32'h14)) i_cwh_central (.mclk(mclk), .rst_b(rst_b),
      .lk(lk), .arm_cmd(arm_cmd), .trouble(trouble), .combination(combination), .armed(armed), .busy(busy),
      .disarm_pulse(disarm_pulse), .err_push(err_push), .err_code(err_code), .err_unit(err_unit),
      .codewords(codewords));
   cwh_keypad #(.LAMP_CYC(32'hC8), .STRIKE_CYC(32'h32), .FLASH_BIT(2)) i_cwh_keypad (
      .mclk(mclk), .rst_b(rst_b), .lk(lk), .arm_button(arm_button), .door_closed(door_closed),
      .digit_valid(digit_valid), .digit(digit), .digit_ready(digit_ready), .trouble_lamp(trouble_lamp),
      .strike(strike), .codeword(codeword));
   cwh_link_checker i_chk (.mclk(mclk), .rst_b(rst_b),
      .c2k_valid(lk.c2k_valid), .c2k_type(lk.c2k_type), .c2k_unit(lk.c2k_unit), .c2k_data(lk.c2k_data),
      .k2c_valid(lk.k2c_valid), .k2c_type(lk.k2c_type), .k2c_unit(lk.k2c_unit), .k2c_data(lk.k2c_data));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (e !== s) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic wrap_up();
      if (err_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   // one sweep of both units: unit 0 answers, unit 1 never does
   task automatic hs(input logic a);
      int n;
      n = 0;
      exp_q.push_back(8'h81);
      // a keypad arm request needs sync, send and latch before busy rises
      repeat (8) @(posedge mclk);
      while (busy !== 1'b0 && n < 600) begin
         @(posedge mclk);
         n++;
      end
      chk("busy", 8'h00, {7'h0, busy});
      chk("central cw", cw_exp, codewords[0]);
      chk("keypad cw", cw_exp, codeword);
      chk("unit1 cw", 8'h00, codewords[1]);
      chk("armed", {7'h0, a}, {7'h0, armed});
      chk("lamp", 8'h01, {7'h0, trouble_lamp});
   endtask : hs
   // digits are offered only while the keypad is ready for one
   task automatic keyin(input logic [15:0] c);
      int n;
      for (int i = 3; i >= 0; i--) begin
         n = 0;
         while (digit_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
         end
         digit_valid <= 1'b1;
         digit <= c[i*4 +: 4];
         @(posedge mclk);
         digit_valid <= 1'b0;
         @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
   endtask : keyin
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_count++;
         wrap_up();
      end
      if (lk.c2k_valid === 1'b1 && lk.c2k_unit === 1'b0 && lk.c2k_type === cwh_pkg::CWH_MSG_DATA1) hi <= lk.c2k_data[3:0];
      if (lk.c2k_valid === 1'b1 && lk.c2k_unit === 1'b0 && lk.c2k_type === cwh_pkg::CWH_MSG_DATA2) cw_exp <= {hi, lk.c2k_data[3:0]};
   end
   always @(negedge mclk) begin
      obs = {err_push, disarm_pulse, disarm_pulse && lk.c2k_type === cwh_pkg::CWH_MSG_STRIKE, 4'h0,
             err_push ? err_unit : lk.c2k_data[0]};
      if (rst_b === 1'b1 && (err_push === 1'b1 || disarm_pulse === 1'b1)) begin
         if (exp_q.size() == 0) chk("event", 8'h00, obs);
         else chk("event", exp_q.pop_front(), obs);
         if (err_push === 1'b1) chk("err code", 8'h01, err_code);
      end
   end
   initial begin
      rst_b = 1'b0;
      {arm_cmd, trouble, arm_button, door_closed, digit_valid} = 5'h00;
      combination = 16'h0000;
      digit = 4'h0;
      cw_exp = 8'h00;
      hi = 4'h0;
      rnd = 32'h8100;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      hs(1'b0);
      arm_cmd <= 1'b1;
      @(posedge mclk);
      arm_cmd <= 1'b0;
      hs(1'b1);
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         comb[i*4 +: 4] = 4'(rnd % 12);
      end
      tr = rnd[8];
      combination <= comb;
      trouble <= tr;
      // last digit off by one bit stays inside 0..11 and must not unlock
      keyin(comb ^ 16'h0001);
      chk("armed kept", 8'h01, {7'h0, armed});
      exp_q.push_back({7'h30, tr});
      keyin(comb);
      chk("armed off", 8'h00, {7'h0, armed});
      chk("strike", 8'h01, {7'h0, strike});
      n_hi = 0;
      repeat (16) begin
         @(posedge mclk);
         n_hi += int'(trouble_lamp === 1'b1);
      end
      chk("lamp highs", tr ? 8'h08 : 8'h10, 8'(n_hi));
      trouble <= 1'b0;
      repeat (60) @(posedge mclk);
      chk("strike off", 8'h00, {7'h0, strike});
      arm_button <= 1'b1;
      door_closed <= 1'b1;
      hs(1'b1);
      arm_button <= 1'b0;
      chk("notes left", 8'h00, 8'(exp_q.size()));
      wrap_up();
   end
endmodule : codeword_handshake_unlock_test
